// ### hdl/xyc_pkg.sv
// Purpose : shared constants and types of the x/y curve sampler
// Assumes : 200 MHz clock, channel values are signed 32-bit counts
// Notes   : byte offsets of the axi4-lite register map live here
package xyc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned MIN_SAMPLE_NS   = 100000;
  localparam int unsigned TICK_CYC        =
    (MIN_SAMPLE_NS * 1000) / CLK_PERIOD_PS;
  // ==========================================================
  // curve memory and accepted ranges
  localparam int unsigned CURVE_DEPTH     = 5000;
  localparam int unsigned IDX_W           = 13;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam logic [31:0] CHAN_RES        = 32'h0000_0001;
  localparam logic [31:0] INT_MAX         = 32'h000f_423f;
  localparam logic [31:0] TPER_MIN        = 32'h0000_0001;
  localparam logic [31:0] TPER_MAX        = 32'h3b9a_a2f0;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_XINT    = 8'h04;
  localparam logic [7:0] OFF_YINT    = 8'h08;
  localparam logic [7:0] OFF_TPER    = 8'h0c;
  localparam logic [7:0] OFF_YREF    = 8'h10;
  localparam logic [7:0] OFF_YTRIG   = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_COUNT   = 8'h1c;
  localparam logic [7:0] OFF_RDIDX   = 8'h20;
  localparam logic [7:0] OFF_RDX     = 8'h24;
  localparam logic [7:0] OFF_RDY     = 8'h28;
  localparam logic [7:0] OFF_XOFS    = 8'h2c;
  localparam logic [7:0] OFF_RETIDX  = 8'h30;
  localparam logic [7:0] OFF_LIVEX   = 8'h34;
  // ==========================================================
  // reset values and response codes
  localparam logic [31:0] CTRL_RST   = 32'h0000_0004;
  localparam logic [31:0] XINT_RST   = 32'h0000_0001;
  localparam logic [31:0] YINT_RST   = 32'h0000_0001;
  localparam logic [31:0] TPER_RST   = 32'h0000_000a;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    REF_ABS = 3'h0, REF_FINAL = 3'h1, REF_LINE_UP = 3'h2,
    REF_LINE_DN = 3'h3, REF_TRIG_UP = 3'h4, REF_TRIG_DN = 3'h5
  } xyc_ref_t;
  typedef enum logic [1:0] {
    RET_XMIN = 2'h0, RET_XMAX = 2'h1, RET_YMIN = 2'h2, RET_YMAX = 2'h3
  } xyc_ret_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MEAS = 2'b01, ST_DONE = 2'b11
  } xyc_state_t;
  typedef struct packed {
    logic signed [31:0] x;
    logic signed [31:0] y;
  } xyc_pair_t;
  typedef struct packed {
    logic [2:0]  ref_mode;
    logic        rec_to_ret;
    logic [1:0]  ret_sel;
    logic        t_en;
    logic        y_en;
    logic        x_en;
  } xyc_ctrl_t;
endpackage

// ### hdl/xyc_sampler.sv
// Purpose : x/y curve recorder with reference shifting, axi4-lite access
// Assumes : sensor pairs arrive on a valid/ready stream, meas_active_in
//           is the level of the measurement phase
// Notes   : the final and line shifts are applied on readback, not by rewriting; the trigger shift is applied as pairs are stored
`timescale 1ns/1ps

// ============================================================
// small fifo in the sensor data path
module xyc_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rp_q];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_in;
        wp_q        <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // xyc_fifo

// ============================================================
// top: sampler, reference logic and register slave
module xyc_sampler
  import xyc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // sensor pair stream
  input  wire logic        pair_valid_in,
  output logic             pair_ready_out,
  input  wire xyc_pair_t   pair_in,
  // measurement phase from the press controller
  input  wire logic        meas_active_in,
  // live absolute pair and curve done
  output xyc_pair_t        live_pair_out,
  output logic             curve_done_out,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // state
  typedef struct packed {
    xyc_state_t         st;
    xyc_ctrl_t          ctrl;
    logic [31:0]        xint;
    logic [31:0]        yint;
    logic [31:0]        tper;
    logic signed [31:0] yref;
    logic signed [31:0] ytrig;
    logic [IDX_W-1:0]   rd_idx;
    logic [14:0]        div;
    logic               slot;
    logic [31:0]        tcnt;
    logic               meas_d;
    logic               have_prev;
    logic signed [31:0] y_prev;
    logic               trig_seen;
    logic signed [31:0] x_zero;
    logic               line_seen;
    logic signed [31:0] line_x;
    logic [IDX_W-1:0]   count;
    logic signed [31:0] last_x;
    logic signed [31:0] last_y;
    logic signed [31:0] ext;
    logic [IDX_W-1:0]   ret_idx;
    logic signed [31:0] ret_x;
    logic signed [31:0] xofs;
    xyc_pair_t          live;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } xyc_regs_t;

  xyc_regs_t          s_q;
  xyc_regs_t          s_d;
  logic signed [31:0] mem_x_q [CURVE_DEPTH];
  logic signed [31:0] mem_y_q [CURVE_DEPTH];
  logic               mem_we;
  logic [IDX_W-1:0]   mem_wa;
  xyc_pair_t          mem_wd;

  // fifo drain side
  logic               f_valid;
  logic               f_ready;
  xyc_pair_t          f_pair;

  xyc_fifo #(
    .WIDTH ($bits(xyc_pair_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (pair_valid_in),
    .in_ready_out  (pair_ready_out),
    .in_data_in    (pair_in),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready),
    .out_data_out  (f_pair)
  );

  // a finished curve holds the stream back until the next start,
  // so pairs that arrive between phases wait; the oldest is popped unused in the start cycle
  assign f_ready = (s_q.st != ST_DONE) || (meas_active_in && !s_q.meas_d);

  // ==========================================================
  // helpers
  function automatic logic [31:0] clamp_u(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction

  function automatic logic [32:0] absdiff(input logic signed [31:0] a,
                                          input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    return d[32] ? 33'(-d) : 33'(d);
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // next state
  logic               take;
  logic               crossed_up;
  logic               crossed_dn;
  logic               trig_now;
  logic               pass;
  logic signed [31:0] x_st;
  logic [31:0]        wv;
  logic               wr_go;
  logic               rd_go;
  logic               is_ext;
  logic signed [31:0] cand;

  always_comb begin
    s_d        = s_q;
    take       = 1'b0;
    trig_now   = 1'b0;
    pass       = 1'b0;
    x_st       = f_pair.x;
    wv         = '0;
    is_ext     = 1'b0;
    cand       = '0;
    crossed_up = s_q.have_prev && (s_q.y_prev < s_q.ytrig)
                 && (f_pair.y >= s_q.ytrig);
    crossed_dn = s_q.have_prev && (s_q.y_prev > s_q.ytrig)
                 && (f_pair.y <= s_q.ytrig);
    mem_we     = 1'b0;
    mem_wa     = s_q.count;
    mem_wd     = f_pair;
    s_d.meas_d = meas_active_in;

    // 0.1 ms slot: at most one stored pair per slot
    if (s_q.div == 15'(TICK_CYCLES - 1)) begin
      s_d.div  = '0;
      s_d.slot = 1'b1;
      if (s_q.tcnt != 32'hffff_ffff) s_d.tcnt = s_q.tcnt + 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    unique case (s_q.st)
      ST_IDLE, ST_DONE: begin
        if (meas_active_in && !s_q.meas_d) begin
          s_d.st        = ST_MEAS;
          s_d.count     = '0;
          s_d.have_prev = 1'b0;
          s_d.trig_seen = 1'b0;
          s_d.line_seen = 1'b0;
          s_d.x_zero    = '0;
          s_d.line_x    = '0;
          s_d.xofs      = '0;
          s_d.ret_idx   = '0;
          s_d.ret_x     = '0;
        end
      end
      ST_MEAS: begin
        if (f_valid) begin
          s_d.live      = f_pair;
          s_d.have_prev = 1'b1;
          s_d.y_prev    = f_pair.y;
          // reference line crossing in absolute x
          if (!s_q.line_seen && s_q.have_prev &&
              (((s_q.ctrl.ref_mode == REF_LINE_UP) &&
                (s_q.y_prev < s_q.yref) && (f_pair.y >= s_q.yref)) ||
               ((s_q.ctrl.ref_mode == REF_LINE_DN) &&
                (s_q.y_prev > s_q.yref) && (f_pair.y <= s_q.yref)))) begin
            s_d.line_seen = 1'b1;
            s_d.line_x    = f_pair.x;
          end
          // trigger arming: nothing stored before the crossing
          if (s_q.ctrl.ref_mode inside {REF_TRIG_UP, REF_TRIG_DN}) begin
            trig_now = !s_q.trig_seen &&
                       (((s_q.ctrl.ref_mode == REF_TRIG_UP) && crossed_up)
                     || ((s_q.ctrl.ref_mode == REF_TRIG_DN) && crossed_dn));
            if (trig_now) begin
              s_d.trig_seen = 1'b1;
              s_d.x_zero    = f_pair.x;
            end
          end
          x_st = 32'(f_pair.x - (trig_now ? f_pair.x : s_q.x_zero));
          // any enabled criterion, first pair of a curve always passes
          pass = (s_q.count == '0) ||
                 (s_q.ctrl.x_en &&
                  (absdiff(f_pair.x, s_q.last_x) >= 33'(s_q.xint))) ||
                 (s_q.ctrl.y_en &&
                  (absdiff(f_pair.y, s_q.last_y) >= 33'(s_q.yint))) ||
                 (s_q.ctrl.t_en && (s_q.tcnt >= s_q.tper));
          take = pass && s_q.slot &&
                 (s_q.count != IDX_W'(CURVE_DEPTH)) &&
                 (!(s_q.ctrl.ref_mode inside {REF_TRIG_UP, REF_TRIG_DN})
                  || s_q.trig_seen || trig_now);
          if (take) begin
            mem_we      = 1'b1;
            mem_wd.x    = x_st;
            s_d.count   = s_q.count + 1'b1;
            s_d.last_x  = f_pair.x;
            s_d.last_y  = f_pair.y;
            // restart the period so two stores are a full period apart;
            // the take cycle is the first cycle of the new period
            s_d.div     = 15'h1;
            s_d.slot    = 1'b0;
            s_d.tcnt    = '0;
            // return point: first occurrence of the chosen extreme
            unique case (s_q.ctrl.ret_sel)
              RET_XMIN: begin
                cand = x_st;
                is_ext = (x_st < s_q.ext);
              end
              RET_XMAX: begin
                cand = x_st;
                is_ext = (x_st > s_q.ext);
              end
              RET_YMIN: begin
                cand = f_pair.y;
                is_ext = (f_pair.y < s_q.ext);
              end
              RET_YMAX: begin
                cand = f_pair.y;
                is_ext = (f_pair.y > s_q.ext);
              end
            endcase
            if (is_ext || (s_q.count == '0)) begin
              s_d.ext     = cand;
              s_d.ret_idx = s_q.count;
              s_d.ret_x   = x_st;
            end
          end
        end
        if (!meas_active_in) begin
          s_d.st = ST_DONE;
          // this cycle's values, so a pair taken as the phase ends counts
          if (s_q.ctrl.rec_to_ret && (s_d.count != '0)) begin
            s_d.count = s_d.ret_idx + 1'b1;
          end
          unique case (s_q.ctrl.ref_mode)
            // return point is the last forward point; with no
            // return segment it is the last point itself
            REF_FINAL: s_d.xofs = s_d.ret_x;
            REF_LINE_UP, REF_LINE_DN:
              s_d.xofs = s_d.line_seen ? s_d.line_x : '0;
            default: s_d.xofs = '0;
          endcase
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // ---- register writes: address and data taken together
    wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      unique case (s_axi_awaddr)
        OFF_CTRL: begin
          wv = wmask(32'(s_q.ctrl), s_axi_wdata, s_axi_wstrb);
          s_d.ctrl = wv[8:0];
          if (wv[8:6] > 3'(REF_TRIG_DN)) s_d.ctrl.ref_mode = REF_ABS;
        end
        OFF_XINT: begin
          wv = wmask(s_q.xint, s_axi_wdata, s_axi_wstrb);
          s_d.xint = clamp_u(wv, CHAN_RES, INT_MAX);
        end
        OFF_YINT: begin
          wv = wmask(s_q.yint, s_axi_wdata, s_axi_wstrb);
          s_d.yint = clamp_u(wv, CHAN_RES, INT_MAX);
        end
        OFF_TPER: begin
          wv = wmask(s_q.tper, s_axi_wdata, s_axi_wstrb);
          s_d.tper = clamp_u(wv, TPER_MIN, TPER_MAX);
        end
        OFF_YREF:  s_d.yref  = wmask(s_q.yref, s_axi_wdata, s_axi_wstrb);
        OFF_YTRIG: s_d.ytrig = wmask(s_q.ytrig, s_axi_wdata, s_axi_wstrb);
        OFF_RDIDX: begin
          wv = wmask(32'(s_q.rd_idx), s_axi_wdata, s_axi_wstrb);
          s_d.rd_idx = wv[IDX_W-1:0];
        end
        OFF_STATUS, OFF_COUNT, OFF_RDX, OFF_RDY,
        OFF_XOFS, OFF_RETIDX, OFF_LIVEX: ;
        default: s_d.bresp = RESP_SLV;
      endcase
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // ---- register reads
    rd_go = s_axi_arvalid && !s_q.rvalid;
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:   s_d.rdata = 32'(s_q.ctrl);
        OFF_XINT:   s_d.rdata = s_q.xint;
        OFF_YINT:   s_d.rdata = s_q.yint;
        OFF_TPER:   s_d.rdata = s_q.tper;
        OFF_YREF:   s_d.rdata = s_q.yref;
        OFF_YTRIG:  s_d.rdata = s_q.ytrig;
        OFF_STATUS: s_d.rdata = {26'h0, s_q.line_seen, s_q.trig_seen,
                      (s_q.count == IDX_W'(CURVE_DEPTH)), s_q.st, 1'b0};
        OFF_COUNT:  s_d.rdata = 32'(s_q.count);
        OFF_RDX: begin
          if (s_q.rd_idx < s_q.count)
            // shift only once the phase is over
            s_d.rdata = 32'(mem_x_q[s_q.rd_idx] -
                        ((s_q.st == ST_DONE) ? s_q.xofs : 32'h0));
          else
            s_d.rdata = '0;
        end
        OFF_RDY:
          s_d.rdata = (s_q.rd_idx < s_q.count) ? mem_y_q[s_q.rd_idx] : '0;
        OFF_XOFS:   s_d.rdata = s_q.xofs;
        OFF_RETIDX: s_d.rdata = 32'(s_q.ret_idx);
        OFF_LIVEX:  s_d.rdata = s_q.live.x;
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLV;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.ctrl <= CTRL_RST[8:0];
      s_q.xint <= XINT_RST;
      s_q.yint <= YINT_RST;
      s_q.tper <= TPER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // curve storage has no reset; count bounds every read
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem_x_q[mem_wa] <= mem_wd.x;
      mem_y_q[mem_wa] <= mem_wd.y;
    end
  end

  // ==========================================================
  // outputs
  assign live_pair_out  = s_q.live;
  assign curve_done_out = (s_q.st == ST_DONE);
  assign s_axi_awready  = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_wready   = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign s_axi_bvalid   = s_q.bvalid;
  assign s_axi_bresp    = s_q.bresp;
  assign s_axi_arready  = !s_q.rvalid;
  assign s_axi_rvalid   = s_q.rvalid;
  assign s_axi_rresp    = s_q.rresp;
  assign s_axi_rdata    = s_q.rdata;
endmodule // xyc_sampler

// ### verif/xyc_chk.sv
// Purpose : port checks for the x/y curve sampler
// Assumes : one clock, sync active-low reset
// Notes   : bound from the bench top file
`timescale 1ns/1ps
module xyc_chk (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // bus, stream and phase
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        meas_active_in,
  input wire logic        pair_ready_out,
  input wire logic        curve_done_out
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take_s |=> s_axi_bvalid)
    else $error("write answer late");
  rd_resp_a: assert property (
    rd_take_s |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  aw_join_a: assert property (
    s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid)
    else $error("write taken alone");
  fifo_free_a: assert property (
    $rose(rst_n_in) |-> pair_ready_out)
    else $error("stream refused after reset");
  done_a: assert property (
    $fell(meas_active_in) |-> ##[1:8] curve_done_out)
    else $error("curve not finished");
  restart_a: assert property (
    $rose(meas_active_in) |-> ##[1:8] !curve_done_out)
    else $error("phase not restarted");
endmodule // xyc_chk

// ### verif/xyc_sensor.sv
// Purpose : sensor front-end model, ramp x=n and y=2n
// Assumes : n restarts at zero when a stream begins
// Notes   : payload is inverted while no pair is offered
`timescale 1ns/1ps
module xyc_sensor
  import xyc_pkg::*;
(
  // clock and control
  input  wire logic          clk_in,
  input  wire logic          go_in,
  // pair stream
  input  wire logic          ready_in,
  output logic               valid_out = 1'b0,
  output xyc_pair_t          pair_out,
  output logic signed [31:0] last_x_out
);
  logic signed [31:0] n_q = '0;
  assign pair_out = valid_out ? {n_q, n_q <<< 1} : ~{n_q, n_q <<< 1};
  always @(posedge clk_in) begin
    if (valid_out && ready_in) begin
      last_x_out <= n_q;
      n_q        <= n_q + 1;
    end else if (!valid_out && !go_in) begin
      n_q <= '0;
    end
    // a pair once offered is held until taken
    valid_out <= go_in || (valid_out && !ready_in);
  end
endmodule // xyc_sensor

// ### verif/xyc_sampler_bench.sv
// Purpose : self-checking bench for the x/y curve sampler
// Assumes : sampling slot shortened to 4 cycles
// Notes   : count bounds follow from 400 beats at one per cycle
`timescale 1ns/1ps
module xyc_sampler_bench;
  import xyc_pkg::*;
  localparam int unsigned TK = 4;
  logic               clk_in = 1'b0;
  logic               rst_n_in = 1'b0;
  logic               go = 1'b0, meas = 1'b0;
  logic               aw = 1'b0, w = 1'b0, b = 1'b0, ar = 1'b0, r = 1'b0;
  logic [7:0]         aa = '0, ra = '0;
  logic [31:0]        wd = '0, rdat, v;
  logic [1:0]         br, rr;
  logic               awr, bv, arr, rv, pv, pr, done;
  xyc_pair_t          pd, live;
  logic signed [31:0] lastx;
  int                 n_errors = 0, n_compared = 0;
  initial forever #2.5 clk_in = ~clk_in;
  xyc_sensor i_xyc_sensor (.clk_in(clk_in), .go_in(go), .ready_in(pr),
    .valid_out(pv), .pair_out(pd), .last_x_out(lastx));
  xyc_sampler #(.TICK_CYCLES(TK)) i_xyc_sampler (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .pair_valid_in(pv), .pair_ready_out(pr),
    .pair_in(pd), .meas_active_in(meas), .live_pair_out(live),
    .curve_done_out(done), .s_axi_awaddr(aa), .s_axi_awvalid(aw),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w), .s_axi_wready(), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_araddr(ra),
    .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r));
  // ==========================================================
  // bus tasks and checks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    aa <= a;
    wd <= d;
    aw <= 1'b1;
    w  <= 1'b1;
    do @(posedge clk_in); while (!awr);
    aw <= 1'b0;
    w  <= 1'b0;
    do @(posedge clk_in); while (!bv);
    // ready a cycle late, so the answer has to be held
    b <= 1'b1;
    @(posedge clk_in);
    b <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    ra <= a;
    ar <= 1'b1;
    do @(posedge clk_in); while (!arr);
    ar <= 1'b0;
    do @(posedge clk_in); while (!rv);
    r <= 1'b1;
    @(posedge clk_in);
    d = rdat;
    r <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, v);
    chk(v, exp);
  endtask
  task automatic run(input int n);
    meas <= 1'b1;
    go   <= 1'b1;
    repeat (n) @(posedge clk_in);
    go <= 1'b0;
    // let the fifo drain before the phase ends
    repeat (8) @(posedge clk_in);
    meas <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    logic [7:0]  ca [6] = '{OFF_XINT, OFF_XINT, OFF_YINT, OFF_YINT,
                            OFF_TPER, OFF_TPER};
    logic [31:0] cw [6] = '{32'hffff_ffff, 32'h0, 32'hffff_ffff, 32'h0,
                            32'hffff_ffff, 32'h0};
    logic [31:0] ce [6] = '{INT_MAX, CHAN_RES, INT_MAX, CHAN_RES,
                            TPER_MAX, TPER_MIN};
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rc(OFF_CTRL, CTRL_RST);
    rc(OFF_XINT, XINT_RST);
    rc(OFF_YINT, YINT_RST);
    rc(OFF_TPER, TPER_RST);
    foreach (ca[i]) begin
      axi_wr(ca[i], cw[i]);
      rc(ca[i], ce[i]);
    end
    axi_rd(8'h40, v);
    chk(32'(rr), 32'(RESP_SLV));
    for (int m = 0; m < 8; m++) begin
      axi_wr(OFF_CTRL, 32'(m) << 6);
      axi_rd(OFF_CTRL, v);
      chk(32'(v[8:6]), (m < 6) ? 32'(m) : 32'h0);
    end
    axi_wr(OFF_CTRL, 32'h0000_0005);
    run(400);
    rc(OFF_XOFS, 32'h0);
    axi_rd(OFF_COUNT, v);
    chk(32'(v >= 32'h5f && v <= 32'h65), 32'h1);
    axi_wr(OFF_YTRIG, 32'h0000_0064);
    axi_wr(OFF_CTRL, 32'h0000_0105);
    run(400);
    axi_rd(OFF_COUNT, v);
    chk(32'(v >= 32'h55 && v <= 32'h59), 32'h1);
    axi_wr(OFF_RDIDX, 32'h0);
    rc(OFF_RDX, 32'h0);
    axi_wr(OFF_RDIDX, 32'h1);
    rc(OFF_RDX, 32'(TK));
    axi_wr(OFF_CTRL, 32'h0000_004d);
    run(400);
    chk(live.x, lastx);
    axi_rd(OFF_COUNT, v);
    axi_wr(OFF_RDIDX, v - 32'h1);
    rc(OFF_RDX, 32'h0);
    axi_wr(OFF_YREF, 32'h0000_0064);
    axi_wr(OFF_CTRL, 32'h0000_00b5);
    run(400);
    rc(OFF_XOFS, 32'h0000_0032);
    rc(OFF_COUNT, 32'h1);
    axi_wr(OFF_RDIDX, 32'h0);
    rc(OFF_RDX, 32'hffff_ffce);
    axi_wr(OFF_CTRL, 32'h0000_0005);
    run(20400);
    rc(OFF_COUNT, 32'(CURVE_DEPTH));
    axi_rd(OFF_STATUS, v);
    chk(32'(v[3]), 32'h1);
    axi_wr(OFF_RDIDX, 32'h0);
    rc(OFF_RDX, 32'h0);
    axi_wr(OFF_RDIDX, 32'(CURVE_DEPTH - 1));
    rc(OFF_RDX, 32'(TK * (CURVE_DEPTH - 1)));
    print_verdict();
  end
endmodule // xyc_sampler_bench
bind xyc_sampler xyc_chk i_xyc_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .meas_active_in(meas_active_in), .pair_ready_out(pair_ready_out),
  .curve_done_out(curve_done_out));
